// ---- common/uart_fifo_pkg.sv ----
// constants, register map and field layout of the uart fifo control block
// assumes a 32-bit classic wishbone slave port and 8-bit characters
package uart_fifo_pkg;
  localparam int DATA_W = 8;
  localparam int DEPTH = 16;
  localparam int CNT_W = 5;
  localparam int PTR_W = 4;
  localparam int ADR_W = 8;
  localparam int IRQ_W = 4;
  localparam logic [CNT_W-1:0] DEPTH_CNT = 5'h10;

  // byte addresses of the word registers
  localparam logic [ADR_W-1:0] FIFO_CONTROL_OFS = 8'h00;
  localparam logic [ADR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [ADR_W-1:0] IRQ_STATUS_OFS = 8'h08;
  localparam logic [ADR_W-1:0] IRQ_MASK_OFS = 8'h0C;
  localparam logic [ADR_W-1:0] TX_DATA_OFS = 8'h10;
  localparam logic [ADR_W-1:0] RX_DATA_OFS = 8'h14;

  // fifo_control fields
  localparam int FCR_EN_BIT = 0;
  localparam int FCR_RX_CLR_BIT = 1;
  localparam int FCR_TX_CLR_BIT = 2;
  localparam int FCR_DMA_BIT = 3;
  localparam int FCR_TRIG_LSB = 6;
  localparam logic [1:0] FCR_TRIG_RST = 2'h0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  // status register fields
  localparam int ST_TX_CNT_LSB = 0;
  localparam int ST_RX_CNT_LSB = 8;
  localparam int ST_TX_EMPTY_BIT = 16;
  localparam int ST_TX_FULL_BIT = 17;
  localparam int ST_RX_EMPTY_BIT = 18;
  localparam int ST_RX_FULL_BIT = 19;
  localparam int ST_RX_INT_BIT = 20;

  // irq status / mask bits
  localparam int IRQ_RX_TRIG = 0;
  localparam int IRQ_TX_EMPTY = 1;
  localparam int IRQ_RX_TIMEOUT = 2;
  localparam int IRQ_RX_OVERRUN = 3;

  // receive trigger levels per receive_trigger_field code
  localparam logic [CNT_W-1:0] TRIG_LVL_0 = 5'h01;
  localparam logic [CNT_W-1:0] TRIG_LVL_1 = 5'h04;
  localparam logic [CNT_W-1:0] TRIG_LVL_2 = 5'h08;
  localparam logic [CNT_W-1:0] TRIG_LVL_3 = 5'h0E;

  typedef enum logic {DMA_MODE_0, DMA_MODE_1} dma_mode_t;

  function automatic logic [CNT_W-1:0] trig_level(input logic [1:0] code);
    case (code)
      2'h0: trig_level = TRIG_LVL_0;
      2'h1: trig_level = TRIG_LVL_1;
      2'h2: trig_level = TRIG_LVL_2;
      default: trig_level = TRIG_LVL_3;
    endcase
  endfunction
endpackage

// ---- verilog/char_fifo.sv ----
// sixteen-entry character fifo held in flip-flops
// assumes push and pop are single-cycle strobes; clear wins over both
`timescale 1ns/100ps
module char_fifo
  import uart_fifo_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic single_i,
  input wire logic push_i,
  input wire logic [uart_fifo_pkg::DATA_W-1:0] data_i,
  input wire logic pop_i,
  output logic [uart_fifo_pkg::DATA_W-1:0] data_o,
  output logic [uart_fifo_pkg::CNT_W-1:0] count_o,
  output logic full_o,
  output logic empty_o
);
  typedef struct packed {
    logic [DEPTH-1:0][DATA_W-1:0] mem;
    logic [PTR_W-1:0] wr;
    logic [PTR_W-1:0] rd;
    logic [CNT_W-1:0] cnt;
  } fifo_t;

  fifo_t s_q;
  fifo_t s_d;
  logic do_push;
  logic do_pop;

  // single entry stands in for the holding register with fifos off
  assign full_o = single_i ? (s_q.cnt != '0) : (s_q.cnt == DEPTH_CNT);
  assign empty_o = (s_q.cnt == '0);
  assign do_push = push_i && !full_o;
  assign do_pop = pop_i && !empty_o;
  assign data_o = s_q.mem[s_q.rd];
  assign count_o = s_q.cnt;

  always_comb begin
    s_d = s_q;
    if (clear_i) begin
      s_d.wr = '0;
      s_d.rd = '0;
      s_d.cnt = '0;
    end else begin
      if (do_push) begin
        s_d.mem[s_q.wr] = data_i;
        s_d.wr = s_q.wr + 4'h1;
      end
      if (do_pop) begin
        s_d.rd = s_q.rd + 4'h1;
      end
      if (do_push && !do_pop) begin
        s_d.cnt = s_q.cnt + 5'h01;
      end else if (do_pop && !do_push) begin
        s_d.cnt = s_q.cnt - 5'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ---- verilog/uart_fifo_ctrl.sv ----
// fifo control, dma ready pins and receive trigger for one uart channel
// assumes a classic wishbone master, and a receiver and transmitter
// that strobe rx_push_i / tx_pop_i once per character
// Behaviour
// - receive interrupt when fill equals trigger
// - receive fifo keeps filling until full
// - trigger codes select 1, 4, 8, 14
// - control bits five, four ignored, read zero
// - bit three selects dma mode 0/1
// - mode 0 transmit ready low when empty
// - mode 0 receive ready low while data held
// - mode 1 transmit ready high only when full
// - mode 1 receive ready on trigger/timeout, until empty
// - bit two clears transmit fifo, self-clears
// - bit one clears receive fifo, self-clears
// - bit zero enables both fifos
// - writes with bit zero clear drop other bits
// - receive interrupt drops below trigger level
//
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
module uart_fifo_ctrl
  import uart_fifo_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [uart_fifo_pkg::ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic rx_push_i,
  input wire logic [uart_fifo_pkg::DATA_W-1:0] rx_data_i,
  input wire logic rx_timeout_i,
  input wire logic tx_pop_i,
  output logic [uart_fifo_pkg::DATA_W-1:0] tx_data_o,
  output logic tx_empty_o,
  output logic transmit_ready_pin_n_o,
  output logic receive_ready_pin_n_o,
  output logic receive_data_int_o,
  output logic irq_o
);
  import uart_fifo_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic fifo_en;
    dma_mode_t dma_mode;
    logic [1:0] trig;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic tx_rdy_n;
    logic rx_rdy_n;
    logic rx_act;
    logic rx_lvl;
    logic tx_empty_prev;
  } ctl_t;

  localparam ctl_t CTL_RST = '{
    dma_mode: DMA_MODE_0,
    trig: FCR_TRIG_RST,
    irq_mask: IRQ_MASK_RST,
    rx_rdy_n: 1'b1,
    tx_empty_prev: 1'b1,
    default: '0
  };

  ctl_t s_q;
  ctl_t s_d;

  logic acc;
  logic wr;
  logic rd;
  logic fcr_wr;
  logic tx_push;
  logic rx_pop;
  logic tx_clr;
  logic rx_clr;
  logic mode1;
  logic rx_at_trig;
  logic [CNT_W-1:0] trig_lvl;
  logic [CNT_W-1:0] tx_cnt;
  logic [CNT_W-1:0] rx_cnt;
  logic tx_full;
  logic tx_empty;
  logic rx_full;
  logic rx_empty;
  logic [DATA_W-1:0] rx_head;
  logic [IRQ_W-1:0] ev;

  // one wait state: ack is registered, so the master never sees a
  // combinational path from stb to ack
  assign acc = cyc_i && stb_i && !s_q.ack;
  assign wr = acc && we_i;
  assign rd = acc && !we_i;
  assign fcr_wr = wr && sel_i[0] && (adr_i == FIFO_CONTROL_OFS);
  assign tx_push = wr && sel_i[0] && (adr_i == TX_DATA_OFS);
  assign rx_pop = rd && (adr_i == RX_DATA_OFS);
  assign mode1 = s_q.fifo_en && (s_q.dma_mode == DMA_MODE_1);

  // fifos off: one character stands for the full level
  assign trig_lvl = s_q.fifo_en ? trig_level(s_q.trig) : TRIG_LVL_0;
  assign rx_at_trig = (rx_cnt >= trig_lvl);

  // clear pulses exist only for the write cycle, so the bits
  // never hold a stored one
  always_comb begin
    tx_clr = 1'b0;
    rx_clr = 1'b0;
    if (fcr_wr) begin
      tx_clr = dat_i[FCR_EN_BIT] && dat_i[FCR_TX_CLR_BIT];
      rx_clr = dat_i[FCR_EN_BIT] && dat_i[FCR_RX_CLR_BIT];
      if (dat_i[FCR_EN_BIT] != s_q.fifo_en) begin
        tx_clr = 1'b1;
        rx_clr = 1'b1;
      end
    end
  end

  char_fifo tx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(tx_clr),
    .single_i(!s_q.fifo_en),
    .push_i(tx_push),
    .data_i(dat_i[DATA_W-1:0]),
    .pop_i(tx_pop_i),
    .data_o(tx_data_o),
    .count_o(tx_cnt),
    .full_o(tx_full),
    .empty_o(tx_empty)
  );

  // the shift registers live outside; only the queue is cleared
  char_fifo rx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(rx_clr),
    .single_i(!s_q.fifo_en),
    .push_i(rx_push_i),
    .data_i(rx_data_i),
    .pop_i(rx_pop),
    .data_o(rx_head),
    .count_o(rx_cnt),
    .full_o(rx_full),
    .empty_o(rx_empty)
  );

  always_comb begin
    ev = '0;
    ev[IRQ_RX_TRIG] = rx_at_trig && !s_q.rx_lvl;
    ev[IRQ_TX_EMPTY] = tx_empty && !s_q.tx_empty_prev;
    ev[IRQ_RX_TIMEOUT] = rx_timeout_i;
    // a character past full is dropped by the fifo; only flagged here
    ev[IRQ_RX_OVERRUN] = rx_push_i && rx_full;
  end

  always_comb begin
    s_d = s_q;
    s_d.ack = acc;
    s_d.dat = '0;
    s_d.tx_empty_prev = tx_empty;
    s_d.rx_lvl = rx_at_trig;

    if (fcr_wr) begin
      s_d.fifo_en = dat_i[FCR_EN_BIT];
      if (dat_i[FCR_EN_BIT]) begin
        s_d.dma_mode = dma_mode_t'(dat_i[FCR_DMA_BIT]);
        s_d.trig = dat_i[FCR_TRIG_LSB +: 2];
      end
    end

    // set wins over write-one-to-clear
    s_d.irq_stat = s_q.irq_stat;
    if (wr && sel_i[0] && (adr_i == IRQ_STATUS_OFS)) begin
      s_d.irq_stat = s_q.irq_stat & ~dat_i[IRQ_W-1:0];
    end
    s_d.irq_stat = s_d.irq_stat | ev;
    if (wr && sel_i[0] && (adr_i == IRQ_MASK_OFS)) begin
      s_d.irq_mask = dat_i[IRQ_W-1:0];
    end

    // mode 1 receive ready latches on trigger or timeout, drops on empty
    if (rx_empty) begin
      s_d.rx_act = 1'b0;
    end
    if (rx_at_trig || (rx_timeout_i && !rx_empty)) begin
      s_d.rx_act = 1'b1;
    end

    if (mode1) begin
      s_d.tx_rdy_n = tx_full;
      s_d.rx_rdy_n = !s_d.rx_act;
    end else begin
      s_d.tx_rdy_n = !tx_empty;
      s_d.rx_rdy_n = rx_empty;
    end

    if (rd) begin
      case (adr_i)
        FIFO_CONTROL_OFS: begin
          // clear bits and the unused pair always read zero
          s_d.dat[FCR_EN_BIT] = s_q.fifo_en;
          s_d.dat[FCR_DMA_BIT] = s_q.dma_mode;
          s_d.dat[FCR_TRIG_LSB +: 2] = s_q.trig;
        end
        STATUS_OFS: begin
          s_d.dat[ST_TX_CNT_LSB +: CNT_W] = tx_cnt;
          s_d.dat[ST_RX_CNT_LSB +: CNT_W] = rx_cnt;
          s_d.dat[ST_TX_EMPTY_BIT] = tx_empty;
          s_d.dat[ST_TX_FULL_BIT] = tx_full;
          s_d.dat[ST_RX_EMPTY_BIT] = rx_empty;
          s_d.dat[ST_RX_FULL_BIT] = rx_full;
          s_d.dat[ST_RX_INT_BIT] = s_q.rx_lvl;
        end
        IRQ_STATUS_OFS: s_d.dat[IRQ_W-1:0] = s_q.irq_stat;
        IRQ_MASK_OFS: s_d.dat[IRQ_W-1:0] = s_q.irq_mask;
        RX_DATA_OFS: s_d.dat[DATA_W-1:0] = rx_head;
        default: s_d.dat = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= CTL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign ack_o = s_q.ack;
  assign dat_o = s_q.dat;
  assign tx_empty_o = tx_empty;
  assign transmit_ready_pin_n_o = s_q.tx_rdy_n;
  assign receive_ready_pin_n_o = s_q.rx_rdy_n;
  assign receive_data_int_o = s_q.rx_lvl;
  assign irq_o = |(s_q.irq_stat & s_q.irq_mask);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_trig_reached: assert property (
    s_q.fifo_en && (rx_cnt == trig_lvl) |=> receive_data_int_o)
    else $error("receive interrupt missing at trigger level");

  chk_fill_past_trig: assert property (
    rx_at_trig && rx_push_i && !rx_full && !rx_pop && !rx_clr
    |=> rx_cnt == $past(rx_cnt) + 5'h01)
    else $error("receive fifo stopped filling after trigger");

  chk_trig_decode: assert property (
    s_q.fifo_en && (s_q.trig == 2'h3) |-> trig_lvl == 5'h0E)
    else $error("trigger code 3 not decoded as 14");

  chk_fcr_read_zero: assert property (
    rd && (adr_i == FIFO_CONTROL_OFS)
    |=> dat_o[5:4] == 2'h0 && dat_o[2:1] == 2'h0)
    else $error("unused or clear bits read nonzero");

  chk_dma_select: assert property (
    fcr_wr && dat_i[FCR_EN_BIT]
    |=> s_q.dma_mode == dma_mode_t'($past(dat_i[FCR_DMA_BIT])))
    else $error("dma mode not taken from bit three");

  chk_m0_tx_ready: assert property (
    !mode1 && !fcr_wr && tx_empty |=> !transmit_ready_pin_n_o)
    else $error("mode 0 transmit ready not low when empty");

  chk_m0_rx_ready: assert property (
    !mode1 && !fcr_wr && !rx_empty |=> !receive_ready_pin_n_o)
    else $error("mode 0 receive ready not low with data");

  chk_m1_tx_ready: assert property (
    mode1 && !fcr_wr |=> transmit_ready_pin_n_o == $past(tx_full))
    else $error("mode 1 transmit ready does not follow full");

  chk_m1_rx_idle: assert property (
    mode1 && !fcr_wr && rx_empty ##1 mode1 && rx_empty
    |=> receive_ready_pin_n_o)
    else $error("mode 1 receive ready low with fifo empty");

  chk_tx_clear: assert property (
    fcr_wr && dat_i[FCR_EN_BIT] && dat_i[FCR_TX_CLR_BIT] |=> tx_empty)
    else $error("transmit fifo not emptied by clear");

  chk_rx_clear: assert property (
    fcr_wr && dat_i[FCR_EN_BIT] && dat_i[FCR_RX_CLR_BIT] |=> rx_empty)
    else $error("receive fifo not emptied by clear");

  chk_fifo_enable: assert property (
    fcr_wr |=> s_q.fifo_en == $past(dat_i[FCR_EN_BIT]))
    else $error("fifo enable not written");

  chk_discard_write: assert property (
    fcr_wr && !dat_i[FCR_EN_BIT] |=> $stable(s_q.trig) && $stable(s_q.dma_mode))
    else $error("control bits changed with enable clear");

  chk_int_withdraw: assert property (
    s_q.fifo_en && (rx_cnt < trig_lvl) && !fcr_wr |=> !receive_data_int_o)
    else $error("receive interrupt held below trigger");

  chk_enable_clears: assert property (
    fcr_wr && (dat_i[FCR_EN_BIT] != s_q.fifo_en) |=> tx_empty && rx_empty)
    else $error("enable change did not clear fifos");

  chk_timeout_ready: assert property (
    mode1 && !fcr_wr && rx_timeout_i && !rx_empty && !rx_pop && !rx_clr
    |=> !receive_ready_pin_n_o)
    else $error("receive timeout did not assert receive ready");

  chk_m0_tx_loaded: assert property (
    !mode1 && !fcr_wr && !tx_empty |=> transmit_ready_pin_n_o)
    else $error("mode 0 transmit ready low with data loaded");

  chk_m0_rx_gone: assert property (
    !mode1 && !fcr_wr && rx_empty |=> receive_ready_pin_n_o)
    else $error("mode 0 receive ready low with fifo empty");

  chk_m1_rx_hold: assert property (
    mode1 && !fcr_wr && s_q.rx_act && !rx_empty
    |=> !receive_ready_pin_n_o)
    else $error("mode 1 receive ready released with data held");

  chk_full_hold: assert property (
    rx_full && rx_push_i && !rx_pop && !rx_clr
    |=> rx_cnt == $past(rx_cnt))
    else $error("receive count moved on a push past full");

  chk_timeout_flag: assert property (
    rx_timeout_i |=> s_q.irq_stat[IRQ_RX_TIMEOUT])
    else $error("receive timeout not flagged");

  // main scenarios the bench is expected to reach
  cov_fill_full: cover property (s_q.fifo_en && rx_full);
  cov_m1_timeout: cover property (mode1 && rx_timeout_i && !rx_empty);
  cov_tx_full_m1: cover property (mode1 && tx_full);
  cov_m1_trigger: cover property (mode1 && ev[IRQ_RX_TRIG]);
  cov_irq_out: cover property (irq_o ##1 !irq_o);
endmodule

// ---- verification/line_side_model.sv ----
// receiver/transmitter stand-in on the character side of the fifo block
// assumes callers enter each task just after a rising clock edge
`timescale 1ns/100ps
module line_side_model (
  input wire logic clk_i,
  input wire logic [7:0] tx_data_i,
  output logic rx_push_o,
  output logic [7:0] rx_data_o,
  output logic rx_timeout_o,
  output logic tx_pop_o
);
  logic [7:0] next_char;

  initial begin
    rx_push_o = 1'b0;
    rx_data_o = 8'hA5;
    rx_timeout_o = 1'b0;
    tx_pop_o = 1'b0;
    next_char = 8'h30;
  end

  // back-to-back strobes, one character per cycle
  task automatic push(input int n);
    for (int i = 0; i < n; i++) begin
      rx_push_o <= 1'b1;
      rx_data_o <= next_char;
      next_char = next_char + 8'h01;
      @(posedge clk_i);
    end
    rx_push_o <= 1'b0;
    // released data is scrambled so stale values never look valid
    rx_data_o <= ~rx_data_o;
  endtask

  // the time-out condition is ours to raise, never the block's
  task automatic timeout_pulse();
    rx_timeout_o <= 1'b1;
    @(posedge clk_i);
    rx_timeout_o <= 1'b0;
  endtask

  task automatic pop(output logic [7:0] ch);
    tx_pop_o <= 1'b1;
    @(posedge clk_i);
    ch = tx_data_i;
    tx_pop_o <= 1'b0;
  endtask
endmodule

// ---- verification/tb_uart_fifo_control_dma_ready.sv ----
// self-checking bench for the uart fifo control block
// assumes the block answers wishbone one cycle after taking a request
`timescale 1ns/100ps
module tb_uart_fifo_control_dma_ready;
  import uart_fifo_pkg::*;
  logic clk_i;
  logic rst_i;
  logic cyc_i, stb_i, we_i;
  logic [ADR_W-1:0] adr_i;
  logic [3:0] sel_i, wsel;
  logic [31:0] dat_i, dat_o, rd;
  logic ack_o, rx_push_i, rx_timeout_i, tx_pop_i, tx_empty_o;
  logic [7:0] rx_data_i, tx_data_o, lfsr, ch, exp_ch;
  logic tx_rdy_n, rx_rdy_n, rx_int, irq_o;
  logic [7:0] txq[$];
  int errors = 0, n_checks = 0, cycles = 0, t;

  always #4 clk_i = ~clk_i;

  uart_fifo_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .rx_push_i(rx_push_i),
    .rx_data_i(rx_data_i), .rx_timeout_i(rx_timeout_i),
    .tx_pop_i(tx_pop_i), .tx_data_o(tx_data_o), .tx_empty_o(tx_empty_o),
    .transmit_ready_pin_n_o(tx_rdy_n), .receive_ready_pin_n_o(rx_rdy_n),
    .receive_data_int_o(rx_int), .irq_o(irq_o));

  line_side_model i_line (.clk_i(clk_i), .tx_data_i(tx_data_o),
    .rx_push_o(rx_push_i), .rx_data_o(rx_data_i),
    .rx_timeout_o(rx_timeout_i), .tx_pop_o(tx_pop_i));

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic int trig_of(input logic [1:0] c);
    case (c)
      2'h0: return 1;
      2'h1: return 4;
      2'h2: return 8;
      default: return 14;
    endcase
  endfunction

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // one classic cycle, released only at the edge that sees ack
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= wsel;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    wb(1'b1, a, {24'h0, d}, r);
  endtask

  task automatic settle();
    repeat (2) @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      summarize();
    end
  end

  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'hF;
    wsel = 4'hF;
    dat_i = 32'h0;
    lfsr = 8'h13;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, FIFO_CONTROL_OFS, 32'h0, rd);
    check("ctl reset", rd, 32'h0);
    check("tx rdy reset", tx_rdy_n, 1'b0);
    check("rx rdy reset", rx_rdy_n, 1'b1);
    wr(FIFO_CONTROL_OFS, 8'hC8);
    wb(1'b0, FIFO_CONTROL_OFS, 32'h0, rd);
    check("ctl no enable", rd, 32'h0);
    wr(FIFO_CONTROL_OFS, 8'hF9);
    wb(1'b0, FIFO_CONTROL_OFS, 32'h0, rd);
    check("ctl unused bits", rd, 32'hC9);
    // byte lane 0 off: the write must store nothing
    wsel = 4'hE;
    wr(FIFO_CONTROL_OFS, 8'h00);
    wsel = 4'hF;
    wb(1'b0, FIFO_CONTROL_OFS, 32'h0, rd);
    check("ctl sel0 low", rd, 32'hC9);
    for (int c = 0; c < 4; c++) begin
      wr(FIFO_CONTROL_OFS, {c[1:0], 6'h03});
      t = trig_of(c[1:0]);
      exp_ch = i_line.next_char;
      i_line.push(t - 1);
      settle();
      check("int below trig", rx_int, 1'b0);
      i_line.push(1);
      settle();
      check("int at trig", rx_int, 1'b1);
      check("rx rdy mode0", rx_rdy_n, 1'b0);
      wb(1'b0, RX_DATA_OFS, 32'h0, rd);
      check("rx head", rd, {24'h0, exp_ch});
      settle();
      check("int drop", rx_int, 1'b0);
    end
    i_line.push(4);
    wb(1'b0, STATUS_OFS, 32'h0, rd);
    check("rx count full", rd[19:8], 12'h910);
    wr(FIFO_CONTROL_OFS, 8'hC3);
    wb(1'b0, STATUS_OFS, 32'h0, rd);
    check("rx count clr", rd[12:8], 5'h00);
    wb(1'b0, FIFO_CONTROL_OFS, 32'h0, rd);
    check("rx clr self", rd, 32'hC1);
    check("rx rdy empty", rx_rdy_n, 1'b1);
    wr(FIFO_CONTROL_OFS, 8'h09);
    for (int i = 0; i < 16; i++) begin
      check("tx rdy mode1", tx_rdy_n, 1'b0);
      lfsr = lfsr_next(lfsr);
      txq.push_back(lfsr);
      wr(TX_DATA_OFS, lfsr);
    end
    check("tx rdy full", tx_rdy_n, 1'b1);
    i_line.pop(ch);
    check("tx head", ch, txq.pop_front());
    settle();
    check("tx rdy one free", tx_rdy_n, 1'b0);
    wr(FIFO_CONTROL_OFS, 8'h0D);
    check("tx clr empty", tx_empty_o, 1'b1);
    wb(1'b0, FIFO_CONTROL_OFS, 32'h0, rd);
    check("tx clr self", rd, 32'h09);
    check("irq masked", irq_o, 1'b0);
    wr(FIFO_CONTROL_OFS, 8'h49);
    i_line.push(3);
    settle();
    check("rx rdy below", rx_rdy_n, 1'b1);
    i_line.push(1);
    settle();
    check("rx rdy trig", rx_rdy_n, 1'b0);
    repeat (3) wb(1'b0, RX_DATA_OFS, 32'h0, rd);
    settle();
    check("rx rdy holds", rx_rdy_n, 1'b0);
    wb(1'b0, RX_DATA_OFS, 32'h0, rd);
    settle();
    check("rx rdy empty1", rx_rdy_n, 1'b1);
    i_line.push(1);
    i_line.timeout_pulse();
    settle();
    check("rx rdy timeout", rx_rdy_n, 1'b0);
    wb(1'b0, RX_DATA_OFS, 32'h0, rd);
    wr(FIFO_CONTROL_OFS, 8'h01);
    wr(TX_DATA_OFS, 8'h5A);
    check("tx rdy loaded", tx_rdy_n, 1'b1);
    i_line.pop(ch);
    check("tx char", ch, 8'h5A);
    settle();
    check("tx rdy mode0", tx_rdy_n, 1'b0);
    wr(IRQ_MASK_OFS, 8'h01);
    wr(IRQ_STATUS_OFS, 8'h0F);
    i_line.push(1);
    settle();
    check("irq set", irq_o, 1'b1);
    wr(IRQ_STATUS_OFS, 8'h01);
    check("irq clr", irq_o, 1'b0);
    wr(FIFO_CONTROL_OFS, 8'h00);
    i_line.push(1);
    settle();
    check("rx rdy off", rx_rdy_n, 1'b0);
    wb(1'b0, 8'h20, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    summarize();
  end
endmodule
